// file: hw/ddsl_pkg.sv
// Shared constants and types for the dual DAC serial load logic
package ddsl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CODE_W = 14;
  localparam int ADDR_W = 2;
  localparam int WORD_W = 16;
  localparam int PIN_W = 4;

  // ----------------------------------------------------------------
  // Preset codes and counts
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_ZERO = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_MID = 14'h2000;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BITS_NONE = 5'h00;
  localparam logic [1:0] POR_WAIT = 2'h3;
  localparam logic [1:0] POR_DONE = 2'h0;
  // Two bits per address code: bit 0 loads channel A, bit 1 channel B
  localparam logic [7:0] CHAN_MAP_DEFAULT = 8'he4;
  // Idle pin levels: select high, load high, preset high, zero scale
  localparam logic [PIN_W-1:0] PIN_IDLE = 4'he;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] code;
  } ddsl_word_t;

  typedef struct packed {
    logic [CODE_W-1:0] a;
    logic [CODE_W-1:0] b;
  } ddsl_pair_t;

  typedef struct packed {
    logic cs_n;
    logic load_outputs_n;
    logic preset_n;
    logic preset_midscale;
  } ddsl_pins_t;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_RUN = 2'b01,
    ST_PRESET = 2'b10
  } ddsl_state_t;

endpackage : ddsl_pkg

// file: hw/ddsl_sync.sv
// Two-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps
module ddsl_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      logic next_meta;
      logic next_q;
      always_comb begin
        next_meta = d[i];
        next_q = meta;
      end
      always_ff @(posedge mclk) begin
        if (srst) begin
          meta <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end else begin
          meta <= next_meta;
          q[i] <= next_q;
        end
      end
    end
  endgenerate

endmodule : ddsl_sync

// file: hw/ddsl_shift.sv
// Serial shift register on the link clock
`timescale 1ns/1ps
module ddsl_shift (
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  // Captured word, quasi-static while select is high
  output ddsl_pkg::ddsl_word_t word,
  output logic word_full
);

  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic full;
  logic next_full;
  ddsl_pkg::ddsl_word_t next_word;

  // Select gates the shift; data enters with no stage in between
  always_comb begin
    next_word = word;
    next_full = full;
    if (!cs_n) begin
      next_word = {word[ddsl_pkg::WORD_W-2:0], sdi};
    end
    next_bit_cnt = bit_cnt;
    if (bit_cnt != ddsl_pkg::WORD_BITS) begin
      next_bit_cnt = bit_cnt + 5'h01;
    end
    // Count restarts from zero each frame, so a short frame clears it
    if (!cs_n) begin
      next_full = (next_bit_cnt == ddsl_pkg::WORD_BITS);
    end
  end

  always_ff @(posedge sclk) begin
    word <= next_word;
    full <= next_full;
  end

  // Select high clears the count; the link clock is idle then
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= ddsl_pkg::BITS_NONE;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // Select high clears the count at once, so the flag must outlive it
  always_comb begin
    word_full = full;
  end

  // No reset here: the whole-word check waits until a word is known
  chk_shift_step: assert property (@(posedge sclk)
    (!cs_n && word_full)
    |=> word == {$past(word[ddsl_pkg::WORD_W-2:0]), $past(sdi)})
    else $error("shift register did not advance by one bit");

  chk_shift_entry: assert property (@(posedge sclk)
    !cs_n |=> word[0] == $past(sdi))
    else $error("serial data did not enter the shift register");

endmodule : ddsl_shift

// file: hw/ddsl_top.sv
// Serial load and double-buffered registers of a dual DAC
//
// What this block does
// - Serial data enters shift register directly.
// - Shift one bit per rising serial clock.
// - Select high blocks shifting; host holds low.
// - Select rising copies word to input register.
// - Select never touches the load strobe path.
// - Preset pin forces all four registers.
// - Level select low presets code zero.
// - Level select high presets midscale 0x2000.
// - Level select applies at pin and power-on.
// - Load low makes DAC registers follow inputs.
// - Load acts without any serial clock edge.
// - Level select may be tied static.
// - Word is 16 bits, address then code.
// - Only the last sixteen bits count.
// - Address bits pick the target input register.
// - Word may arrive as two bytes.
`timescale 1ns/1ps
module ddsl_top #(
  parameter logic [7:0] CHAN_MAP = ddsl_pkg::CHAN_MAP_DEFAULT
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  // Control pins
  input wire logic load_outputs_n,
  input wire logic preset_n,
  input wire logic preset_midscale,
  // Register contents
  output ddsl_pkg::ddsl_pair_t input_codes,
  output ddsl_pkg::ddsl_pair_t dac_codes,
  output logic word_dropped
);

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  ddsl_pkg::ddsl_word_t link_word;
  logic link_full;
  // Word and full flag cross with no flops of their own: the link clock
  // stops while select is high, and the select edge is used only after
  // two flops, so both have settled when they are read
  // A new frame must wait until the edge has been taken

  ddsl_shift u_shift (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .word(link_word),
    .word_full(link_full)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ddsl_pkg::ddsl_pins_t pins_raw;
  ddsl_pkg::ddsl_pins_t pins_s;

  always_comb begin
    pins_raw.cs_n = cs_n;
    pins_raw.load_outputs_n = load_outputs_n;
    pins_raw.preset_n = preset_n;
    pins_raw.preset_midscale = preset_midscale;
  end

  // The level select passes the same flops; it is meant to be static
  ddsl_sync #(
    .W(ddsl_pkg::PIN_W),
    .RST_VAL(ddsl_pkg::PIN_IDLE)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .d(pins_raw),
    .q(pins_s)
  );

  // ----------------------------------------------------------------
  // Select edge and preset code
  // ----------------------------------------------------------------
  logic cs_prev;
  logic next_cs_prev;
  logic cs_rise;
  logic [ddsl_pkg::CODE_W-1:0] preset_code;
  logic [1:0] chan_sel;

  always_comb begin
    next_cs_prev = pins_s.cs_n;
    cs_rise = pins_s.cs_n & ~cs_prev;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= next_cs_prev;
    end
  end

  always_comb begin
    if (pins_s.preset_midscale) begin
      preset_code = ddsl_pkg::CODE_MID;
    end else begin
      preset_code = ddsl_pkg::CODE_ZERO;
    end
    // Link word is stable here: the link clock stops while select is high
    chan_sel = CHAN_MAP[{link_word.addr, 1'b0} +: 2];
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  ddsl_pkg::ddsl_state_t state;
  ddsl_pkg::ddsl_state_t next_state;
  logic [1:0] por_cnt;
  logic [1:0] next_por_cnt;
  ddsl_pkg::ddsl_pair_t next_input_codes;
  ddsl_pkg::ddsl_pair_t next_dac_codes;
  logic next_word_dropped;

  always_comb begin
    next_state = state;
    next_por_cnt = por_cnt;
    next_input_codes = input_codes;
    next_dac_codes = dac_codes;
    next_word_dropped = 1'b0;
    case (state)
      ddsl_pkg::ST_POR: begin
        // Wait for the level select to reach the synchroniser output
        next_input_codes.a = preset_code;
        next_input_codes.b = preset_code;
        next_dac_codes.a = preset_code;
        next_dac_codes.b = preset_code;
        if (por_cnt == ddsl_pkg::POR_DONE) begin
          next_state = ddsl_pkg::ST_RUN;
        end else begin
          next_por_cnt = por_cnt - 2'h1;
        end
      end
      ddsl_pkg::ST_RUN: begin
        if (!pins_s.preset_n) begin
          next_state = ddsl_pkg::ST_PRESET;
          next_input_codes.a = preset_code;
          next_input_codes.b = preset_code;
          next_dac_codes.a = preset_code;
          next_dac_codes.b = preset_code;
        end else begin
          if (cs_rise) begin
            if (link_full) begin
              if (chan_sel[0]) begin
                next_input_codes.a = link_word.code;
              end
              if (chan_sel[1]) begin
                next_input_codes.b = link_word.code;
              end
            end else begin
              // Short frames would load stale bits, so they are dropped
              next_word_dropped = 1'b1;
            end
          end
          // Level sensitive and independent of the select pin
          if (!pins_s.load_outputs_n) begin
            next_dac_codes = next_input_codes;
          end
        end
      end
      ddsl_pkg::ST_PRESET: begin
        next_input_codes.a = preset_code;
        next_input_codes.b = preset_code;
        next_dac_codes.a = preset_code;
        next_dac_codes.b = preset_code;
        if (pins_s.preset_n) begin
          next_state = ddsl_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = ddsl_pkg::ST_POR;
        next_por_cnt = ddsl_pkg::POR_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ddsl_pkg::ST_POR;
      por_cnt <= ddsl_pkg::POR_WAIT;
      input_codes <= '0;
      dac_codes <= '0;
      word_dropped <= 1'b0;
    end else begin
      state <= next_state;
      por_cnt <= next_por_cnt;
      input_codes <= next_input_codes;
      dac_codes <= next_dac_codes;
      word_dropped <= next_word_dropped;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  logic run_ok;
  always_comb begin
    run_ok = (state == ddsl_pkg::ST_RUN) && pins_s.preset_n;
  end

  chk_preset_zero: assert property (
    (state != ddsl_pkg::ST_POR && !pins_s.preset_n
      && !pins_s.preset_midscale)
    |=> input_codes == '0 && dac_codes == '0)
    else $error("zero-scale preset not applied");

  chk_preset_mid: assert property (
    (state != ddsl_pkg::ST_POR && !pins_s.preset_n
      && pins_s.preset_midscale)
    |=> input_codes.a == ddsl_pkg::CODE_MID
      && input_codes.b == ddsl_pkg::CODE_MID
      && dac_codes.a == ddsl_pkg::CODE_MID
      && dac_codes.b == ddsl_pkg::CODE_MID)
    else $error("midscale preset not applied");

  chk_por_level: assert property (
    state == ddsl_pkg::ST_POR
    |=> dac_codes.a == ($past(pins_s.preset_midscale) ?
      ddsl_pkg::CODE_MID : ddsl_pkg::CODE_ZERO))
    else $error("power-on preset ignores the level select");

  chk_por_exit: assert property (
    state == ddsl_pkg::ST_POR |-> ##[1:4] state == ddsl_pkg::ST_RUN)
    else $error("power-on preset did not finish");

  chk_load_follow: assert property (
    (run_ok && !pins_s.load_outputs_n) |=> dac_codes == input_codes)
    else $error("DAC registers not transparent under load");

  chk_dac_hold: assert property (
    (run_ok && pins_s.load_outputs_n) |=> $stable(dac_codes))
    else $error("DAC registers changed without load");

  chk_cs_load_a: assert property (
    (run_ok && cs_rise && link_full && chan_sel[0])
    |=> input_codes.a == $past(link_word.code))
    else $error("channel A input register not loaded");

  chk_cs_load_b: assert property (
    (run_ok && cs_rise && link_full && chan_sel[1])
    |=> input_codes.b == $past(link_word.code))
    else $error("channel B input register not loaded");

  chk_short_drop: assert property (
    (run_ok && cs_rise && !link_full)
    |=> word_dropped && $stable(input_codes))
    else $error("short frame was not dropped");

  chk_input_hold: assert property (
    (run_ok && !cs_rise) |=> $stable(input_codes) && !word_dropped)
    else $error("input register changed without select edge");

  // ----------------------------------------------------------------
  // Sequencing checks
  // ----------------------------------------------------------------
  // Preset must win over a select edge or load in the same cycle
  chk_preset_enter: assert property (
    (state == ddsl_pkg::ST_RUN && !pins_s.preset_n)
    |=> state == ddsl_pkg::ST_PRESET)
    else $error("preset pin did not take over the registers");

  chk_preset_leave: assert property (
    (state == ddsl_pkg::ST_PRESET && pins_s.preset_n)
    |=> state == ddsl_pkg::ST_RUN)
    else $error("preset state did not end with the pin");

  chk_por_count: assert property (
    (state == ddsl_pkg::ST_POR && por_cnt != ddsl_pkg::POR_DONE)
    |=> state == ddsl_pkg::ST_POR)
    else $error("power-on preset ended early");

  chk_por_inputs: assert property (
    state == ddsl_pkg::ST_POR
    |=> input_codes.b == ($past(pins_s.preset_midscale) ?
      ddsl_pkg::CODE_MID : ddsl_pkg::CODE_ZERO)
      && input_codes.a == input_codes.b && dac_codes.b == input_codes.b)
    else $error("power-on preset missed a register");

  chk_addr_none: assert property (
    (run_ok && cs_rise && link_full && chan_sel == 2'h0)
    |=> $stable(input_codes))
    else $error("unmapped address changed an input register");

  // A select edge alone must leave the DAC registers latched
  chk_cs_no_dac: assert property (
    (run_ok && cs_rise && pins_s.load_outputs_n)
    |=> $stable(dac_codes))
    else $error("select edge reached the DAC registers");

  chk_drop_cause: assert property (
    word_dropped |-> $past(cs_rise) && !$past(link_full))
    else $error("drop flagged without a short frame");

endmodule : ddsl_top

// file: tb/ddsl_host.sv
// Host-side serial link driver for the dual DAC load logic
`timescale 1ns/1ps
module ddsl_host (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    // Select settles high just after start so the bit counter clears
    #1 cs_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // Frame driver, 12 ns link clock only inside frames
  // ----------------------------------------------------------------
  // Idle data shows the inverse so a late sample cannot pass by luck
  task automatic send(input logic [31:0] bits, input int n, input bit keep);
    // Start off the mclk edge at which the caller handed over
    #2;
    cs_n = 1'b0;
    #6;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    // Pad keeps select low long enough for the mclk synchroniser
    #60;
    if (!keep) begin
      cs_n = 1'b1;
    end
    sdi = ~sdi;
  endtask : send
endmodule : ddsl_host

// file: tb/testbench.sv
// Self-checking bench for the dual DAC serial load logic
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [15:0] word;
    int nbits;
    logic [13:0] exp_a;
    logic [13:0] exp_b;
    int exp_drop;
  } ddsl_row_t;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic load_outputs_n = 1'b1;
  logic preset_n = 1'b1;
  logic preset_midscale = 1'b0;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic word_dropped;
  ddsl_pkg::ddsl_pair_t input_codes;
  ddsl_pkg::ddsl_pair_t dac_codes;
  int n_mismatch = 0;
  int check_count = 0;
  int drops = 0;
  ddsl_row_t rows [5] = '{
    '{16'h5234, 16, 14'h1234, 14'h0000, 0},
    '{16'hbfff, 16, 14'h1234, 14'h3fff, 0},
    '{16'hc001, 16, 14'h0001, 14'h0001, 0},
    '{16'h2aaa, 16, 14'h0001, 14'h0001, 0},
    '{16'h0012, 8, 14'h0001, 14'h0001, 1}};

  always #20 mclk = ~mclk;

  ddsl_top dut_u (
    .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .load_outputs_n(load_outputs_n), .preset_n(preset_n),
    .preset_midscale(preset_midscale), .input_codes(input_codes),
    .dac_codes(dac_codes), .word_dropped(word_dropped)
  );

  ddsl_host host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  always @(posedge mclk) begin
    if (word_dropped === 1'b1) begin
      drops <= drops + 1;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic ddsl_pkg::ddsl_pair_t mk(logic [13:0] a, logic [13:0] b);
    mk = '{a: a, b: b};
  endfunction : mk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_cyc

  task automatic chk_pair(input ddsl_pkg::ddsl_pair_t got,
                          input ddsl_pkg::ddsl_pair_t exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_pair

  task automatic chk_cnt(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got,
               exp);
    end
  endtask : chk_cnt

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  initial begin
    #2000000;
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int d0;
    ddsl_row_t r;
    wait_cyc(3);
    srst <= 1'b0;
    wait_cyc(8);
    chk_pair(input_codes, mk(14'h0000, 14'h0000), "por in");
    chk_pair(dac_codes, mk(14'h0000, 14'h0000), "por dac");
    $display("test power-on done");
    for (int i = 0; i < 5; i++) begin
      d0 = drops;
      r = rows[i];
      host_u.send({16'h0000, r.word}, r.nbits, 1'b0);
      wait_cyc(8);
      chk_pair(input_codes, mk(r.exp_a, r.exp_b), "row in");
      chk_pair(dac_codes, mk(14'h0000, 14'h0000), "row dac");
      chk_cnt(drops - d0, r.exp_drop, "row drop");
    end
    $display("test rows done");
    host_u.send(32'h00ff8155, 24, 1'b0);
    wait_cyc(8);
    chk_pair(input_codes, mk(14'h0001, 14'h0155), "long");
    host_u.send(32'h00000045, 8, 1'b1);
    wait_cyc(2);
    host_u.send(32'h00000067, 8, 1'b0);
    wait_cyc(8);
    chk_pair(input_codes, mk(14'h0567, 14'h0155), "bytes");
    $display("test long and split frames done");
    load_outputs_n <= 1'b0;
    wait_cyc(6);
    chk_pair(dac_codes, mk(14'h0567, 14'h0155), "load");
    host_u.send(32'h00004042, 16, 1'b0);
    wait_cyc(8);
    chk_pair(dac_codes, mk(14'h0042, 14'h0155), "follow");
    load_outputs_n <= 1'b1;
    wait_cyc(6);
    host_u.send(32'h00004100, 16, 1'b0);
    wait_cyc(8);
    chk_pair(dac_codes, mk(14'h0042, 14'h0155), "hold");
    chk_pair(input_codes, mk(14'h0100, 14'h0155), "hold in");
    $display("test load strobe done");
    preset_n <= 1'b0;
    wait_cyc(6);
    chk_pair(input_codes, mk(14'h0000, 14'h0000), "zero in");
    chk_pair(dac_codes, mk(14'h0000, 14'h0000), "zero dac");
    preset_n <= 1'b1;
    preset_midscale <= 1'b1;
    wait_cyc(6);
    preset_n <= 1'b0;
    wait_cyc(6);
    chk_pair(input_codes, mk(14'h2000, 14'h2000), "mid in");
    chk_pair(dac_codes, mk(14'h2000, 14'h2000), "mid dac");
    preset_n <= 1'b1;
    wait_cyc(6);
    $display("test preset pin done");
    srst <= 1'b1;
    wait_cyc(3);
    srst <= 1'b0;
    wait_cyc(8);
    chk_pair(input_codes, mk(14'h2000, 14'h2000), "por mid in");
    chk_pair(dac_codes, mk(14'h2000, 14'h2000), "por mid dac");
    $display("test midscale power-on done");
    end_sim();
  end
endmodule : testbench
